// >>> core/mrip_ctrl.v
// Reset, idle and power-down controller with AHB-Lite register port
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mrip_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Sources map to vectors 0003h..004Bh at 8-byte steps; PCA polled before UART.
// - Any reset restarts fetch at address 0000h with registers initialized.
// - Reset input high 24 oscillator periods is a valid reset, any speed mode.
// - Watchdog expiry drives a 96-clock reset pulse onto the reset pin.
// - Setting halt bit enters idle right after the writing instruction.
// - Idle gates only the CPU clock; peripherals keep running, state kept.
// - Idle freezes ports and drives address-latch and fetch strobes high.
// - Enabled interrupt in idle clears halt bit; resume after idle instruction.
// - Hardware reset ends idle after 24 oscillator periods.
// - Two user flag bits hold their value through idle.
// - Power-down stops oscillator after invoking instruction; RAM and registers kept.
// - Power-down ends only on reset, enabled external or keypad interrupt.
// - Keypad wake counts 1024 clocks before leaving power-down.
// - Oscillator restarts while wake pin low; exit completes when released.
// - With both pins enabled, first release ends exit; higher priority served.
// - Reset exit reinitializes registers; interrupt exit leaves them; RAM kept.
// - Halt and power-down set together: clear both on vector, no idle.
// - Power-down drives strobes low; port 0 floats with external program memory.
// - Port 0 in low power drives only zero; a one floats.
module mrip_ctrl #(
   parameter KBD_WAKE_CYCLES = `MRIP_KBD_WAKE,
   parameter P0_W = 8
)(
   // Clock and reset
   input wire clk,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Pins from outside
   input wire rst_pin_in,
   input wire external_irq_a_n,
   input wire external_irq_b_n,
   input wire keypad_irq_n,
   // Reset pin drive and watchdog
   input wire wdt_expire,
   output wire rst_pin_out,
   output wire rst_pin_oe,
   // Interrupt controller side
   input wire [`MRIP_NUM_SRC-1:0] irq_pending,
   input wire [`MRIP_NUM_SRC-1:0] irq_enable,
   input wire irq_vector_taken,
   input wire ext_irq_a_prio_hi,
   // CPU side
   input wire instr_done,
   output reg cpu_clk_en,
   output reg periph_clk_en,
   output reg osc_run,
   output reg core_rst,
   output reg [15:0] fetch_vector,
   // Port and strobe control
   input wire [P0_W-1:0] p0_latch,
   output reg port_freeze,
   output reg ale_force,
   output reg ale_force_val,
   output reg program_fetch_strobe_force_val,
   output reg p2_addr_en,
   output reg [P0_W-1:0] p0_out,
   output reg [P0_W-1:0] p0_oe
);

   // Sequencer states
   localparam ST_RUN = 3'd0;
   localparam ST_IDLE = 3'd1;
   localparam ST_PDOWN = 3'd2;
   localparam ST_WAKE = 3'd3;
   localparam ST_KWAIT = 3'd4;
   localparam RST_CW = 5;
   localparam WDT_CW = 7;

   // Priority table: polling order of source numbers 1..10
   function [3:0] poll_src;
      input [9:0] req;
      begin
         poll_src = 4'd0;
         if (req[0]) poll_src = 4'd1;
         else if (req[1]) poll_src = 4'd2;
         else if (req[2]) poll_src = 4'd3;
         else if (req[3]) poll_src = 4'd4;
         else if (req[6]) poll_src = 4'd7;
         else if (req[4]) poll_src = 4'd5;
         else if (req[5]) poll_src = 4'd6;
         else if (req[7]) poll_src = 4'd8;
         else if (req[8]) poll_src = 4'd9;
         else if (req[9]) poll_src = 4'd10;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg [3:0] s1_q;
   reg [3:0] s2_q;
   always @(posedge clk)
   begin
      if (rst)
      begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
      end
      else
      begin
         s1_q <= {rst_pin_in, ~external_irq_a_n, ~external_irq_b_n, ~keypad_irq_n};
         s2_q <= s1_q;
      end
   end
   // Synchronised pin levels, active high
   wire rst_s = s2_q[3];
   wire int_a = s2_q[2];
   wire int_b = s2_q[1];
   wire kbd = s2_q[0];

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin qualification and watchdog pulse
   reg [RST_CW-1:0] rcnt_q;
   reg [WDT_CW-1:0] wcnt_q;
   wire wdt_active = (wcnt_q != {WDT_CW{1'b0}});
   wire rst_valid = (rcnt_q == `MRIP_RST_MIN_OSC - 1) && rst_s;
   always @(posedge clk)
   begin
      if (rst)
      begin
         rcnt_q <= {RST_CW{1'b0}};
         wcnt_q <= {WDT_CW{1'b0}};
      end
      else
      begin
         // Count high cycles; same in any speed mode
         if (!rst_s)
            rcnt_q <= {RST_CW{1'b0}};
         else if (rcnt_q != `MRIP_RST_MIN_OSC - 1)
            rcnt_q <= rcnt_q + 1'b1;
         if (wdt_expire && !wdt_active)
            wcnt_q <= `MRIP_WDT_PULSE;
         else if (wdt_active)
            wcnt_q <= wcnt_q - 1'b1;
      end
   end
   // Pin driven high only while the watchdog pulse runs
   assign rst_pin_out = 1'b1;
   assign rst_pin_oe = wdt_active;

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   reg wr_q;
   reg rd_q;
   reg [11:0] addr_q;
   wire acc = hsel && hready && htrans[1];
   always @(posedge clk)
   begin
      if (rst || rst_valid)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 12'h000;
      end
      else
      begin
         wr_q <= acc && hwrite;
         rd_q <= acc && !hwrite;
         addr_q <= acc ? haddr : addr_q;
      end
   end
   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Power control register and sequencer
   reg [7:0] pwr_q;
   reg [7:0] cfg_q;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg [10:0] kcnt_q;
   reg irq_exit_q;
   wire halt_b = pwr_q[`MRIP_BIT_HALT];
   wire pd_b = pwr_q[`MRIP_BIT_PDOWN];
   reg [1:0] held_q;
   wire ext_prog = cfg_q[0];
   wire any_irq = |(irq_pending & irq_enable);
   // Wake and exit qualifiers
   wire wa = int_a && irq_enable[0];
   wire wb = int_b && irq_enable[2];
   wire wk = kbd && irq_enable[7];
   wire pwr_wr = wr_q && (addr_q == `MRIP_OFF_PWR_CTRL);
   // First release of either external interrupt pin seen low during the wake ends the exit
   wire wake_done = (held_q[0] && !int_a) || (held_q[1] && !int_b);

   // Next state
   always @*
   begin
      st_d = st_q;
      case (st_q)
         ST_RUN:
            if (instr_done && pd_b) st_d = ST_PDOWN;
            else if (instr_done && halt_b) st_d = ST_IDLE;
         ST_IDLE:
            if (any_irq) st_d = ST_RUN;
         ST_PDOWN:
            if (wa || wb) st_d = ST_WAKE;
            else if (wk) st_d = ST_KWAIT;
         ST_WAKE:
            if (wake_done) st_d = ST_RUN;
         ST_KWAIT:
            if (kcnt_q == KBD_WAKE_CYCLES - 1) st_d = ST_RUN;
         default:
            st_d = ST_RUN;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst || rst_valid)
      begin
         // Reset reinitializes registers and ends idle/power-down
         st_q <= ST_RUN;
         pwr_q <= `MRIP_PWR_RST;
         cfg_q <= `MRIP_CFG_RST;
         kcnt_q <= 11'd0;
         irq_exit_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         kcnt_q <= (st_q == ST_KWAIT) ? kcnt_q + 1'b1 : 11'd0;
         irq_exit_q <= (st_q != ST_RUN) && (st_d == ST_RUN) ? 1'b1 :
            (irq_vector_taken ? 1'b0 : irq_exit_q);
         if (wr_q && addr_q == `MRIP_OFF_CONFIG)
            cfg_q <= hwdata[7:0];
         // Hardware clear of both bits wins when leaving low power
         if ((st_q == ST_IDLE && any_irq) || (irq_exit_q && irq_vector_taken))
         begin
            pwr_q[`MRIP_BIT_HALT] <= 1'b0;
            pwr_q[`MRIP_BIT_PDOWN] <= 1'b0;
         end
         else if (pwr_wr)
            pwr_q <= hwdata[7:0];   // Flags keep value through idle
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake pins seen low since leaving power-down
   always @(posedge clk)
   begin
      if (rst || rst_valid)
         held_q <= 2'b00;
      else if (st_d == ST_WAKE)
         held_q <= held_q | {wb, wa};
      else
         held_q <= 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock gating, reset and vector outputs
   always @(posedge clk)
   begin
      if (rst)
      begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_run <= 1'b1;
         core_rst <= 1'b1;
         fetch_vector <= `MRIP_VEC_RESET;
      end
      else
      begin
         cpu_clk_en <= (st_d == ST_RUN);
         periph_clk_en <= (st_d != ST_PDOWN);
         osc_run <= (st_d != ST_PDOWN);
         core_rst <= rst_valid;
         if (rst_valid)
            fetch_vector <= `MRIP_VEC_RESET;
         else if (any_irq)
            fetch_vector <= `MRIP_VEC_BASE + {8'h00, (poll_src(irq_pending & irq_enable)
               - 4'd1), 3'b000};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port and strobe state in low power
   integer i;
   always @(posedge clk)
   begin
      if (rst)
      begin
         port_freeze <= 1'b0;
         ale_force <= 1'b0;
         ale_force_val <= 1'b1;
         program_fetch_strobe_force_val <= 1'b1;
         p2_addr_en <= 1'b0;
         p0_out <= {P0_W{1'b0}};
         p0_oe <= {P0_W{1'b0}};
      end
      else
      begin
         port_freeze <= (st_d != ST_RUN);
         ale_force <= (st_d != ST_RUN);
         ale_force_val <= (st_d == ST_IDLE);
         program_fetch_strobe_force_val <= (st_d == ST_IDLE);
         p2_addr_en <= (st_d == ST_IDLE) && ext_prog;
         p0_out <= {P0_W{1'b0}};
         for (i = 0; i < P0_W; i = i + 1)
            p0_oe[i] <= (st_d == ST_RUN) || (!ext_prog && !p0_latch[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status word seen by software
   wire [7:0] status_w = {kbd, int_b, int_a, irq_exit_q, wdt_active, st_q};

   // Read data
   always @*
   begin
      hrdata = 32'h00000000;
      if (rd_q)
         case (addr_q)
            `MRIP_OFF_PWR_CTRL: hrdata = {24'h000000, pwr_q};
            `MRIP_OFF_STATUS: hrdata = {24'h000000, status_w};
            `MRIP_OFF_VECTOR: hrdata = {16'h0000, fetch_vector};
            `MRIP_OFF_CONFIG: hrdata = {24'h000000, cfg_q};
            default: hrdata = 32'h00000000;
         endcase
   end

   // belongs to the outside party; ext_irq_a_prio_hi is unused, poll_src fixes service order
   wire unused_ok = ext_irq_a_prio_hi | (|hsize) | htrans[0];

endmodule // mrip_ctrl
`default_nettype wire

// >>> core/mrip_consts.vh
// Constants for the reset, idle and power-down controller
`ifndef MRIP_CONSTS_VH
`define MRIP_CONSTS_VH
// Register byte offsets
`define MRIP_OFF_PWR_CTRL 12'h000
`define MRIP_OFF_STATUS 12'h004
`define MRIP_OFF_VECTOR 12'h008
`define MRIP_OFF_CONFIG 12'h00C
// Power control field positions
`define MRIP_BIT_HALT 0
`define MRIP_BIT_PDOWN 1
`define MRIP_BIT_FLAG_A 2
`define MRIP_BIT_FLAG_B 3
// Reset values
`define MRIP_PWR_RST 8'h00
`define MRIP_CFG_RST 8'h00
// Timing figures
`define MRIP_RST_MIN_OSC 24
`define MRIP_WDT_PULSE 7'h60
`define MRIP_KBD_WAKE 1024
// Vectors
`define MRIP_VEC_RESET 16'h0000
`define MRIP_VEC_BASE 16'h0003
`define MRIP_VEC_STEP 16'h0008
`define MRIP_NUM_SRC 10
`endif

// >>> test/mrip_ctrl_chk.sv
// Checker for the reset, idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module mrip_ctrl_chk #(parameter P0_W = 8)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins and events
   input wire logic rst_pin_in,
   input wire logic rst_pin_oe,
   input wire logic keypad_irq_n,
   input wire logic instr_done,
   // Core side
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_run,
   input wire logic core_rst,
   input wire logic [15:0] fetch_vector,
   input wire logic ale_force_val,
   input wire logic program_fetch_strobe_force_val,
   // Port 0 state
   input wire logic port_freeze,
   input wire logic [P0_W-1:0] p0_latch,
   input wire logic [P0_W-1:0] p0_oe,
   input wire logic [P0_W-1:0] p0_out
);
   logic [7:0] pin_cnt_q;
   logic [7:0] oe_cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Run lengths of pin level and own reset drive
   always @(posedge clk)
   begin
      if (rst)
      begin
         pin_cnt_q <= 8'h00;
         oe_cnt_q <= 8'h00;
      end
      else
      begin
         pin_cnt_q <= rst_pin_in ? pin_cnt_q + {7'h00, pin_cnt_q != 8'hFF} : 8'h00;
         oe_cnt_q <= rst_pin_oe ? oe_cnt_q + 8'h01 : 8'h00;
      end
   end
   // Keypad wake seen while stopped
   sequence kbd_wake;
      $fell(keypad_irq_n) && !osc_run;
   endsequence
   a_pin_reset: assert property ($rose(core_rst) |-> pin_cnt_q >= 8'h18)
      else $error("core reset after short pin pulse");
   a_wdt_len: assert property ($fell(rst_pin_oe) |-> oe_cnt_q == 8'h60)
      else $error("reset drive length wrong");
   a_halt_entry: assert property ($fell(cpu_clk_en) |-> $past(instr_done))
      else $error("cpu clock stopped mid instruction");
   a_idle_periph: assert property (!cpu_clk_en && osc_run |-> periph_clk_en)
      else $error("peripheral clock stopped in idle");
   a_idle_strobes: assert property ($fell(cpu_clk_en) && osc_run |->
      ale_force_val && program_fetch_strobe_force_val)
      else $error("strobes not high in idle");
   a_pd_strobes: assert property ($fell(osc_run) |-> !ale_force_val && !program_fetch_strobe_force_val)
      else $error("strobes not low in power-down");
   a_p0_zero: assert property (p0_out == {P0_W{1'b0}} &&
      (!port_freeze || (p0_oe & $past(p0_latch)) == {P0_W{1'b0}}))
      else $error("port 0 drives a one");
   a_vec_reset: assert property (core_rst |-> fetch_vector == 16'h0000)
      else $error("restart address not zero");
   a_kbd_delay: assert property (kbd_wake |-> !cpu_clk_en [*8])
      else $error("keypad wake too early");
endmodule // mrip_ctrl_chk
bind mrip_ctrl mrip_ctrl_chk #(.P0_W(P0_W)) i_chk (.clk, .rst, .rst_pin_in, .rst_pin_oe,
   .keypad_irq_n, .instr_done, .cpu_clk_en, .periph_clk_en, .osc_run, .core_rst,
   .fetch_vector, .ale_force_val, .program_fetch_strobe_force_val, .port_freeze, .p0_latch, .p0_oe,
   .p0_out);
`default_nettype wire

// >>> test/mrip_ext_model.sv
// Model of the external reset circuit and wake sources
`timescale 1ns/1ps
`default_nettype none
module mrip_ext_model #(parameter SUPPLY_WAIT = 4)(
   // Clock
   input wire logic clk,
   // Reset pin
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   output wire logic rst_pin_in,
   // Wake pins
   output wire logic external_irq_a_n,
   output wire logic external_irq_b_n,
   output wire logic keypad_irq_n
);
   logic drv_q = 1'b0;
   logic [2:0] irq_q = 3'h7;
   // Pulled-down pin: outside drive or own watchdog drive
   assign rst_pin_in = drv_q | (rst_pin_oe & rst_pin_out);
   assign {keypad_irq_n, external_irq_b_n, external_irq_a_n} = irq_q;
   // Reset pulse of n clocks
   task automatic pin_reset(input int n);
      @(posedge clk);
      drv_q <= 1'b1;
      repeat (n) @(posedge clk);
      drv_q <= 1'b0;
   endtask
   // Wake pin drive; waits for supply before asserting
   task automatic set_irq(input int sel, input logic v);
      if (!v)
         repeat (SUPPLY_WAIT) @(posedge clk);
      @(posedge clk);
      irq_q[sel] <= v;
   endtask
endmodule // mrip_ext_model
`default_nettype wire

// >>> test/tb.sv
// Testbench for the reset, idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int KW = 16;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, wdt_expire = 1'b0;
   logic irq_vector_taken = 1'b0, instr_done = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, rd;
   logic [9:0] irq_pending = 10'h000, irq_enable = 10'h000;
   wire hreadyout, rst_pin_in, rst_pin_out, rst_pin_oe, cpu_clk_en, periph_clk_en, osc_run;
   wire external_irq_a_n, external_irq_b_n, keypad_irq_n, ale_force_val, program_fetch_strobe_force_val;
   wire hresp, port_freeze, ale_force, p2_addr_en;
   wire [31:0] hrdata;
   wire [15:0] fetch_vector;
   wire [7:0] p0_oe;
   int n_mismatch = 0, checks = 0, cnt, i;
   time t0;
   mrip_ctrl #(.KBD_WAKE_CYCLES(KW), .P0_W(8)) i_mrip_ctrl (.clk, .rst, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .rst_pin_in, .external_irq_a_n, .external_irq_b_n, .keypad_irq_n,
      .wdt_expire, .rst_pin_out, .rst_pin_oe, .irq_pending, .irq_enable, .irq_vector_taken,
      .ext_irq_a_prio_hi(1'b0), .instr_done, .cpu_clk_en, .periph_clk_en, .osc_run,
      .core_rst(), .fetch_vector, .p0_latch(8'hA5), .port_freeze, .ale_force,
      .ale_force_val, .program_fetch_strobe_force_val, .p2_addr_en, .p0_out(), .p0_oe);
   mrip_ext_model i_mrip_ext_model (.clk, .rst_pin_out, .rst_pin_oe, .rst_pin_in,
      .external_irq_a_n, .external_irq_b_n, .keypad_irq_n);
   // 25 MHz clock
   initial
   begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_ready;
      @(posedge clk);
      for (cnt = 0; hreadyout !== 1'b1; cnt++)
      begin
         if (cnt > 50)
         begin
            n_mismatch++;
            print_verdict();
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic step;
      @(posedge clk);
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wait_state(input logic [2:0] s);
      for (int k = 0; k < 300; k++)
      begin
         bus(1'b0, 12'h004, 32'h0);
         if (rd[2:0] === s)
            return;
      end
      n_mismatch++;
      print_verdict();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdchk(12'h000, 32'h0);
      check(fetch_vector, 32'h0);
      bus(1'b1, 12'h0F0, 32'hFF);
      rdchk(12'h0F0, 32'h0);
      check({hresp, hreadyout}, 32'h1);
      // Each source alone, then PCA against UART
      irq_enable <= 10'h3FF;
      for (i = 0; i < 10; i++)
      begin
         irq_pending <= 10'h001 << i;
         rdchk(12'h008, 32'h3 + 32'h8 * i);
      end
      irq_pending <= 10'h050;
      rdchk(12'h008, 32'h33);
      irq_pending <= 10'h000;
      // Idle with both flags, woken by an interrupt
      bus(1'b1, 12'h000, 32'hD);
      step();
      check(cpu_clk_en, 32'h0);
      check(periph_clk_en, 32'h1);
      check({ale_force_val, program_fetch_strobe_force_val}, 32'h3);
      irq_pending <= 10'h001;
      repeat (4) @(posedge clk);
      check(cpu_clk_en, 32'h1);
      irq_pending <= 10'h000;
      rdchk(12'h000, 32'hC);
      // Idle ended by pin reset
      bus(1'b1, 12'h000, 32'h1);
      step();
      i_mrip_ext_model.pin_reset(30);
      repeat (6) @(posedge clk);
      check(cpu_clk_en, 32'h1);
      rdchk(12'h000, 32'h0);
      // Watchdog drive length
      @(posedge clk);
      wdt_expire <= 1'b1;
      @(posedge clk);
      wdt_expire <= 1'b0;
      for (cnt = 0; cnt < 10 && rst_pin_oe !== 1'b1; cnt++) @(posedge clk);
      for (cnt = 0; cnt < 200 && rst_pin_oe === 1'b1; cnt++) @(posedge clk);
      check(cnt, 32'd96);
      repeat (40) @(posedge clk);
      // Power-down, stray source, then pin a wake
      irq_enable <= 10'h3FF;
      bus(1'b1, 12'h00C, 32'h1);
      bus(1'b1, 12'h000, 32'h1);
      step();
      check({port_freeze, ale_force, p2_addr_en, p0_oe}, 32'h700);
      irq_pending <= 10'h001;
      repeat (4) @(posedge clk);
      irq_pending <= 10'h000;
      bus(1'b1, 12'h000, 32'hE);
      step();
      check(osc_run, 32'h0);
      check({ale_force_val, program_fetch_strobe_force_val}, 32'h0);
      check(p0_oe, 32'h0);
      check({port_freeze, ale_force, p2_addr_en}, 32'h6);
      irq_pending <= 10'h002;
      repeat (4) @(posedge clk);
      check(osc_run, 32'h0);
      irq_pending <= 10'h000;
      i_mrip_ext_model.set_irq(0, 1'b0);
      repeat (6) @(posedge clk);
      check(osc_run, 32'h1);
      i_mrip_ext_model.set_irq(0, 1'b1);
      wait_state(3'h0);
      @(posedge clk);
      irq_vector_taken <= 1'b1;
      @(posedge clk);
      irq_vector_taken <= 1'b0;
      rdchk(12'h000, 32'hC);
      rdchk(12'h00C, 32'h1);
      // Both bits set, both pins low, release of b alone ends the exit
      bus(1'b1, 12'h000, 32'h3);
      step();
      i_mrip_ext_model.set_irq(0, 1'b0);
      i_mrip_ext_model.set_irq(1, 1'b0);
      repeat (6) @(posedge clk);
      i_mrip_ext_model.set_irq(1, 1'b1);
      wait_state(3'h0);
      irq_pending <= 10'h005;
      repeat (2) @(posedge clk);
      check(fetch_vector, 32'h3);
      irq_vector_taken <= 1'b1;
      @(posedge clk);
      irq_vector_taken <= 1'b0;
      irq_pending <= 10'h000;
      i_mrip_ext_model.set_irq(0, 1'b1);
      step();
      rdchk(12'h000, 32'h0);
      check(cpu_clk_en, 32'h1);
      // Keypad wake waits its count; internal program memory
      bus(1'b1, 12'h00C, 32'h0);
      bus(1'b1, 12'h000, 32'h2);
      step();
      check(p0_oe, 32'h5A);
      i_mrip_ext_model.set_irq(2, 1'b0);
      t0 = $time;
      wait_state(3'h0);
      check(($time - t0) >= KW * 40, 32'h1);
      i_mrip_ext_model.set_irq(2, 1'b1);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
